// file: core/sar_link_pkg.sv
// constants shared by the converter end and the host end of the serial link
// assumes a 40 MHz system clock on both ends
package sar_link_pkg;
   localparam int unsigned RES_W          = 16;
   localparam int unsigned MCLK_PERIOD_NS = 25;
   // conversion time, longest figure, rounds down
   localparam int unsigned CONV_TIME_NS   = 322;
   localparam int unsigned CONV_CYC       = CONV_TIME_NS / MCLK_PERIOD_NS;
   // least acquisition time between conversions, rounds up
   localparam int unsigned ACQ_TIME_NS    = 165;
   localparam int unsigned ACQ_CYC        = (ACQ_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   // window after the start edge in which start may still toggle, rounds down
   localparam int unsigned CNV_WIN_NS     = 40;
   localparam int unsigned CNV_HIGH_CYC   = CNV_WIN_NS / MCLK_PERIOD_NS;
   // settling time after power-on reset, least figure, rounds up
   localparam int unsigned POR_WAIT_NS    = 20000;
   localparam int unsigned POR_WAIT_CYC   = (POR_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [15:0] RESULT_RST     = 16'h0000;
   localparam logic [15:0] CODE_MAX       = 16'h7fff;
   localparam logic [15:0] CODE_MIN       = 16'h8000;
   localparam int unsigned SCK_HALF_CYC   = 4;

   // gain compression: the compressed input span covers 80 percent of full scale,
   // so codes are stretched by 5/4 and clipped at the two's complement limits
   function automatic logic [15:0] gain_expand(input logic [15:0] raw);
      logic signed [17:0] wide;
      wide = $signed({{2{raw[15]}}, raw}) + $signed({{4{raw[15]}}, raw[15:2]});
      if (wide > $signed({2'b00, CODE_MAX})) begin
         gain_expand = CODE_MAX;
      end else if (wide < $signed({2'b11, CODE_MIN})) begin
         gain_expand = CODE_MIN;
      end else begin
         gain_expand = wide[15:0];
      end
   endfunction
endpackage

// file: core/sar_link_if.sv
// pins between one converter and its host controller
// assumes the bench joins the two ends; sdo is modelled with a pull-up
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
   logic conversion_start_pin;
   logic sck;
   logic sdo_out;
   logic sdo_oe;
   logic read_disable_or_serial_in;
   logic busy;
   logic chain_mode;
   logic reference_gain_compress_pin;
   logic sdo_line;

   // released line floats high through the pull-up
   assign sdo_line = sdo_oe ? sdo_out : 1'b1;

   modport converter (
      input  conversion_start_pin, sck, read_disable_or_serial_in,
      input  chain_mode, reference_gain_compress_pin,
      output sdo_out, sdo_oe, busy
   );
   modport host (
      output conversion_start_pin, sck, read_disable_or_serial_in,
      output chain_mode, reference_gain_compress_pin,
      input  sdo_line, busy
   );
endinterface
`default_nettype wire

// file: core/sar_converter.sv
// converter end: conversion timing, auto power-down and serial readout
// assumes mclk_i stands in for the internal oscillator and srst_i for power-on reset
`timescale 1ns/1ps
`default_nettype none
module sar_converter #(
   parameter int unsigned CONV_CYC = sar_link_pkg::CONV_CYC
) (
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   input  wire logic [15:0] sample_i,
   output logic      [15:0] result_o,
   output logic             powered_o,
   sar_link_if.converter    link
);
   typedef enum logic {ST_DOWN, ST_CONVERT} conv_state_t;

   conv_state_t state_q;
   logic [2:0]  start_sync_q;
   logic [1:0]  dgc_sync_q;
   logic [7:0]  cyc_q;
   logic [15:0] held_q;
   logic [15:0] result_q;
   logic        busy_q;
   logic        done_tog_q;
   logic        seen_tog_q;
   logic [15:0] shift_q;
   logic        start_rise;

   ////////////////////////////////////////////////////////////////////////////////
   // system clock side

   // start pin crosses in through two flops; the third only feeds the edge detector
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         start_sync_q <= 3'b000;
         dgc_sync_q   <= 2'b11;
      end else begin
         start_sync_q <= {start_sync_q[1:0], link.conversion_start_pin};
         dgc_sync_q   <= {dgc_sync_q[0], link.reference_gain_compress_pin};
      end
   end

   assign start_rise = start_sync_q[1] & ~start_sync_q[2];

   // conversion sequencer; the counter stands in for the trimmed oscillator
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state_q <= ST_DOWN;
         cyc_q   <= 8'h00;
         held_q  <= sar_link_pkg::RESULT_RST;
      end else begin
         case (state_q)
            ST_DOWN: begin
               if (start_rise) begin
                  state_q <= ST_CONVERT;
                  cyc_q   <= 8'h00;
                  held_q  <= sample_i;              // input frozen at start
               end
            end
            ST_CONVERT: begin
               // start edges seen here are dropped, not queued
               if (cyc_q == 8'(CONV_CYC - 1)) begin
                  state_q <= ST_DOWN;
               end else begin
                  cyc_q <= cyc_q + 8'h01;
               end
            end
            default: state_q <= ST_DOWN;
         endcase
      end
   end

   // result word and busy flag; busy falls in the same edge the result lands
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         result_q   <= sar_link_pkg::RESULT_RST;
         busy_q     <= 1'b0;
         done_tog_q <= 1'b0;
      end else begin
         if (state_q == ST_DOWN && start_rise) begin
            busy_q <= 1'b1;
         end else if (state_q == ST_CONVERT && cyc_q == 8'(CONV_CYC - 1)) begin
            busy_q     <= 1'b0;
            done_tog_q <= ~done_tog_q;              // marks a fresh word for the shifter
            if (!dgc_sync_q[1]) begin
               result_q <= sar_link_pkg::gain_expand(held_q);
            end else begin
               result_q <= held_q;
            end
         end
         // otherwise result stands untouched while powered down
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // link clock side

   // the shift clock stops outside frames, so the fresh-word toggle cannot be
   // synchronised by it; it is read directly because it settles at busy fall and
   // the host gives no clock edge until after busy has fallen
   // the seen copy is cleared without a clock edge: no shift clock runs before the
   // first frame, and a copy left out of step with done_tog_q after a reset would
   // keep the whole next word out of the shifter
   always_ff @(posedge link.sck or posedge srst_i) begin
      if (srst_i) begin
         seen_tog_q <= 1'b0;
      end else begin
         seen_tog_q <= done_tog_q;
      end
   end

   // shifter has no reset; the first edge after a fresh word loads it whole
   always_ff @(posedge link.sck) begin
      if (seen_tog_q != done_tog_q) begin
         shift_q <= {result_q[14:0], link.read_disable_or_serial_in};
      end else begin
         shift_q <= {shift_q[14:0], link.read_disable_or_serial_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pins

   // msb shows straight from the result until the first edge of the frame
   assign link.sdo_out = (seen_tog_q != done_tog_q) ? result_q[15] : shift_q[15];
   // enable follows the pins without a clock so a selected device answers at once
   assign link.sdo_oe  = link.chain_mode | ~link.read_disable_or_serial_in;
   assign link.busy    = busy_q;

   assign result_o  = result_q;
   assign powered_o = busy_q;                       // powered only while converting
endmodule
`default_nettype wire

// file: core/sar_host.sv
// host end: starts conversions, waits on busy and clocks the word out
// assumes the converter end on the far side of sar_link_if
`timescale 1ns/1ps
`default_nettype none
module sar_host #(
   parameter int unsigned FRAME_BITS = sar_link_pkg::RES_W,
   parameter int unsigned POR_WAIT   = sar_link_pkg::POR_WAIT_CYC,
   parameter int unsigned HALF_CYC   = sar_link_pkg::SCK_HALF_CYC
) (
   input  wire logic                  mclk_i,
   input  wire logic                  srst_i,
   input  wire logic                  start_i,
   input  wire logic                  chain_i,
   input  wire logic                  gain_compress_i,
   output logic                       ready_o,
   output logic                       valid_o,
   output logic [FRAME_BITS-1:0]      data_o,
   sar_link_if.host                   link
);
   typedef enum logic [2:0] {ST_SETTLE, ST_IDLE, ST_START, ST_WAIT, ST_SHIFT,
                             ST_ACQ} host_state_t;

   host_state_t           state_q;
   logic [15:0]           cnt_q;
   logic [7:0]            bits_q;
   logic [1:0]            busy_sync_q;
   logic [1:0]            sdo_sync_q;
   logic                  busy_seen_q;
   logic                  cnv_q;
   logic                  sck_q;
   logic                  rdl_q;
   logic                  ready_q;
   logic                  valid_q;
   logic [FRAME_BITS-1:0] data_q;
   logic [FRAME_BITS-1:0] shift_q;

   // busy and data arrive from the other clock; two flops before any use
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         busy_sync_q <= 2'b00;
         sdo_sync_q  <= 2'b11;
      end else begin
         busy_sync_q <= {busy_sync_q[0], link.busy};
         sdo_sync_q  <= {sdo_sync_q[0], link.sdo_line};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer: settle, pulse start, wait busy, shift, keep acquisition gap

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state_q     <= ST_SETTLE;
         cnt_q       <= 16'h0000;
         bits_q      <= 8'h00;
         busy_seen_q <= 1'b0;
         cnv_q       <= 1'b0;
         sck_q       <= 1'b0;
         rdl_q       <= 1'b1;
         valid_q     <= 1'b0;
         data_q      <= '0;
         shift_q     <= '0;
      end else begin
         valid_q <= 1'b0;
         case (state_q)
            ST_SETTLE: begin
               if (cnt_q == 16'(POR_WAIT - 1)) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            ST_IDLE: begin
               if (start_i) begin
                  cnv_q       <= 1'b1;
                  cnt_q       <= 16'h0000;
                  busy_seen_q <= 1'b0;
                  state_q     <= ST_START;
               end
            end
            ST_START: begin
               // start falls inside the quiet window after its rising edge
               if (cnt_q == 16'(sar_link_pkg::CNV_HIGH_CYC - 1)) begin
                  cnv_q   <= 1'b0;
                  state_q <= ST_WAIT;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            ST_WAIT: begin
               // read only once the conversion is over
               if (busy_sync_q[1]) begin
                  busy_seen_q <= 1'b1;
               end else if (busy_seen_q) begin
                  rdl_q   <= chain_i;               // select own device only between conversions
                  cnt_q   <= 16'h0000;
                  bits_q  <= 8'h00;
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               // half period long enough that the synchronised bit is settled
               if (cnt_q == 16'(HALF_CYC - 1)) begin
                  cnt_q <= 16'h0000;
                  sck_q <= ~sck_q;
                  if (!sck_q) begin
                     shift_q <= {shift_q[FRAME_BITS-2:0], sdo_sync_q[1]};
                     bits_q  <= bits_q + 8'h01;
                  end else if (bits_q == 8'(FRAME_BITS)) begin
                     sck_q   <= 1'b0;               // clock parked low
                     rdl_q   <= 1'b1;               // output released, except in chain mode
                     data_q  <= shift_q;
                     valid_q <= 1'b1;
                     state_q <= ST_ACQ;
                  end
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            ST_ACQ: begin
               if (cnt_q == 16'(sar_link_pkg::ACQ_CYC - 1)) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ready only in idle, registered so the port stays a flop
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= (state_q == ST_IDLE) && !start_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pins and user outputs

   assign link.conversion_start_pin        = cnv_q;
   assign link.sck                         = sck_q;
   assign link.read_disable_or_serial_in   = rdl_q;
   assign link.chain_mode                  = chain_i;
   assign link.reference_gain_compress_pin = ~gain_compress_i;
   assign ready_o = ready_q;
   assign valid_o = valid_q;
   assign data_o  = data_q;
endmodule
`default_nettype wire

// file: testbench/sar_link_asserts.sv
// checker: timing relations on the pins between converter and host
// assumes both ends run on mclk_i and share the synchronous reset srst_i
`timescale 1ns/1ps
`default_nettype none
module sar_link_asserts #(
   parameter int unsigned CONV_CYC = 12
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic conversion_start_pin,
   input wire logic sck,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic read_disable_or_serial_in,
   input wire logic busy,
   input wire logic chain_mode
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   logic [7:0] busy_cnt_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // busy length counter; a restart in mid-conversion would stretch it past the limit
   always_ff @(posedge mclk_i) begin
      if (srst_i || !busy)
         busy_cnt_q <= 8'h00;
      else
         busy_cnt_q <= busy_cnt_q + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   property p_start_busy;
      $rose(conversion_start_pin) && !busy |-> ##[1:4] busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("busy did not follow start");
   property p_no_restart;
      busy_cnt_q <= 8'(CONV_CYC);
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("busy held too long");
   property p_busy_len;
      $fell(busy) |-> busy_cnt_q == 8'(CONV_CYC);
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("conversion length wrong");
   property p_start_quiet;
      busy |-> !conversion_start_pin;
   endproperty
   a_start_quiet: assert property (p_start_quiet) else $error("start moved in conversion");
   property p_acq_gap;
      $fell(busy) |-> !conversion_start_pin [*7];
   endproperty
   a_acq_gap: assert property (p_acq_gap) else $error("acquisition gap too short");
   property p_normal_oe;
      !chain_mode |-> sdo_oe == !read_disable_or_serial_in;
   endproperty
   a_normal_oe: assert property (p_normal_oe) else $error("output enable wrong");
   property p_chain_oe;
      chain_mode |-> sdo_oe;
   endproperty
   a_chain_oe: assert property (p_chain_oe) else $error("chain output released");
   property p_sdo_steady;
      $changed(sdo_out) |-> $rose(sck) || $fell(busy) || $changed(read_disable_or_serial_in)
         || $changed(chain_mode);
   endproperty
   a_sdo_steady: assert property (p_sdo_steady) else $error("data moved off clock edge");
   property p_sck_period;
      $rose(sck) |-> sck [*4] ##1 !sck;
   endproperty
   a_sck_period: assert property (p_sck_period) else $error("shift clock period wrong");
   property p_sck_idle;
      busy || (!chain_mode && read_disable_or_serial_in) |-> !sck;
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("shift clock ran while idle");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// testbench: converter and host joined by the link, words checked end to end
// assumes one 40 MHz clock for both ends and a shortened settling count
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {logic [15:0] smp; logic gc; logic ch;} row_t;

   logic        mclk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        start_i = 1'b0;
   logic        chain_i = 1'b0;
   logic        gain_compress_i = 1'b0;
   logic [15:0] sample_i = 16'h0000;
   logic [15:0] result_o;
   logic        powered_o;
   logic        ready_o;
   logic        valid_o;
   logic [15:0] data_o;
   logic [15:0] got;
   int          failures = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          k;
   row_t        rows [8] = '{'{16'h1234, 1'b0, 1'b0}, '{16'h8000, 1'b0, 1'b0},
                             '{16'h7fff, 1'b1, 1'b0}, '{16'h8000, 1'b1, 1'b0},
                             '{16'ha5a5, 1'b0, 1'b1}, '{16'hfffc, 1'b1, 1'b1},
                             '{16'h4000, 1'b1, 1'b0}, '{16'hffff, 1'b1, 1'b0}};

   sar_link_if i_sar_link_if ();
   sar_converter i_sar_converter (.mclk_i(mclk_i), .srst_i(srst_i), .sample_i(sample_i),
      .result_o(result_o), .powered_o(powered_o), .link(i_sar_link_if.converter));
   sar_host #(.POR_WAIT(20)) i_sar_host (.mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i),
      .chain_i(chain_i), .gain_compress_i(gain_compress_i), .ready_o(ready_o),
      .valid_o(valid_o), .data_o(data_o), .link(i_sar_link_if.host));
   sar_link_asserts #(.CONV_CYC(sar_link_pkg::CONV_CYC)) i_sar_link_asserts (
      .mclk_i(mclk_i), .srst_i(srst_i),
      .conversion_start_pin(i_sar_link_if.conversion_start_pin), .sck(i_sar_link_if.sck),
      .sdo_out(i_sar_link_if.sdo_out), .sdo_oe(i_sar_link_if.sdo_oe),
      .read_disable_or_serial_in(i_sar_link_if.read_disable_or_serial_in),
      .busy(i_sar_link_if.busy), .chain_mode(i_sar_link_if.chain_mode));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // clock, and a cycle ceiling well above the nine conversions' worth of traffic
   always #12.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // expected code: stretched by 5/4 and clipped when gain compression is on
   function automatic logic [15:0] expect_code(input logic [15:0] s, input logic g);
      logic signed [17:0] w;
      w = $signed({s[15], s[15], s}) + $signed({{4{s[15]}}, s[15:2]});
      if (!g)
         return s;
      if (w > 18'sh0_7fff)
         return 16'h7fff;
      if (w < -18'sh0_8000)
         return 16'h8000;
      return w[15:0];
   endfunction

   task automatic check(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic tick();
      @(posedge mclk_i);
      #2;
   endtask

   // one full conversion and readout; waits are bounded so a hang ends in the ceiling
   task automatic convert(input logic [15:0] s, input logic g, input logic c);
      sample_i = s;
      gain_compress_i = g;
      chain_i = c;
      k = 0;
      while (ready_o !== 1'b1 && k < 2000) begin
         tick();
         k++;
      end
      start_i = 1'b1;
      tick();
      start_i = 1'b0;
      k = 0;
      while (valid_o !== 1'b1 && k < 2000) begin
         tick();
         k++;
      end
      got = data_o;
   endtask

   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge mclk_i);
      #2;
      srst_i = 1'b0;
      // table of words, modes and gain settings, run back to back
      for (int i = 0; i < 8; i++) begin
         convert(rows[i].smp, rows[i].gc, rows[i].ch);
         check(got, expect_code(rows[i].smp, rows[i].gc));
         check(result_o, expect_code(rows[i].smp, rows[i].gc));
         $display("row %0d done", i);
      end
      // idle after the last word: result kept, device down, shared line released
      repeat (30) tick();
      check(result_o, 16'hfffe);
      check({15'h0000, powered_o}, 16'h0000);
      check({15'h0000, i_sar_link_if.sdo_line}, 16'h0001);
      $display("idle test done");
      // reset in mid-conversion, then the settling wait before the next start
      start_i = 1'b1;
      tick();
      start_i = 1'b0;
      repeat (6) tick();
      srst_i = 1'b1;
      repeat (2) tick();
      srst_i = 1'b0;
      check(result_o, 16'h0000);
      check({15'h0000, ready_o}, 16'h0000);
      k = 0;
      while (ready_o !== 1'b1 && k < 200) begin
         tick();
         k++;
      end
      check(16'(k >= 20), 16'h0001);
      convert(16'h0f0f, 1'b0, 1'b0);
      check(got, 16'h0f0f);
      $display("reset test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
